// ### rtl/ssf_pkg.sv
package ssf_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] REG_INT_FLAGS = 8'h00;
	localparam logic [7:0] REG_INT_MASK = 8'h01;
	localparam logic [7:0] REG_WR_IDX = 8'h02;
	localparam logic [7:0] REG_LOST = 8'h03;
	localparam logic [7:0] REG_RD_IDX = 8'h04;
	localparam logic [7:0] REG_FIFO_PORT = 8'h05;
	localparam logic [7:0] REG_LAST = 8'hFF;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int NUM_FLAGS = 5;
	localparam int FLG_ALMOST = 4;
	localparam int FLG_TEMP = 3;
	localparam int FLG_PULSE = 2;
	localparam int FLG_OXY = 1;
	localparam int FLG_SUPPLY = 0;
	localparam int MASK_LSB = 4;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [3:0] RST_MASK = 4'h0;
	localparam logic [3:0] RST_IDX = 4'h0;
	localparam logic [3:0] RST_LOST = 4'h0;
	localparam logic [3:0] LOST_MAX = 4'hF;
	localparam logic [7:0] READ_NONE = 8'h00;

	// ****************************************
	// Modes, FIFO shape, link framing
	// ****************************************
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_PULSE = 3'h2;
	localparam logic [2:0] MODE_OXY = 3'h3;
	localparam int FIFO_DEPTH = 16;
	localparam int IDX_W = 4;
	localparam int WORD_W = 16;
	localparam int SAMPLE_W = 32;
	localparam logic [1:0] LAST_BYTE = 2'h3;
	localparam logic [1:0] RES_FULL = 2'h3;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_REG = 4'b0011,
		ST_REG_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RACK = 4'b1000
	} ssf_bus_state_type;

endpackage

// ### rtl/ssf_sample_ram.sv
`timescale 1ns/1ps

module ssf_sample_ram #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 32
) (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic we,
	input wire logic [AW-1:0] wa,
	input wire logic [DW-1:0] wd,
	// Read side
	input wire logic [AW-1:0] ra,
	output logic [DW-1:0] rd
);

	// ****************************************
	// Sample slots, circular by index wrap
	// ****************************************
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
	end

	// Unread slots hold no reset value; the host only reads what was pushed
	assign rd = mem[ra];

endmodule

// ### rtl/ssf_top.sv
`timescale 1ns/1ps

// Functional notes
// - Five sources hold interrupt pin low until cleared.
// - Reading flags or data clears all flags.
// - Almost-full when write index equals read minus one.
// - Temperature done sets its flag.
// - Each sample sets pulse flag; data read clears.
// - Oxygen mode sample sets oxygen flag; data read clears.
// - Status bits three to one read zero.
// - Supply rising past lockout sets supply flag.
// - Supply flag unmaskable; brownout disables all masks.
// - Masked source still sets flag, pin released.
// - Write index advances per push; writable when mode not off.
// - Full FIFO drops samples, saturating lost counter.
// - Read index advances per pop; host may rewrite.
// - Sixteen slots, IR word then red word.
// - Data port holds address; index steps every fourth.
// - Other registers auto-increment address in bursts.
// - Address does not wrap past the last.
// - Words left-justified, top bit at fifteen.
// - Pulse-only mode reads third, fourth bytes zero.
// - Mode change keeps indexes; brownout clears them.
// - Mode 010 pulse only, 011 oxygen.
// - Power save forces all flags to zero.

module ssf_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// System
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Serial bus, open drain
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Interrupt, open drain, active low
	output logic INT_N_OUT,
	output logic INT_N_OE,
	// Supply monitor pin
	input wire logic SUPPLY_OK,
	// Operating controls
	input wire logic [2:0] MODE_SEL,
	input wire logic POWER_SAVE,
	// Converter side
	input wire logic SAMPLE_STROBE,
	input wire logic [15:0] SAMPLE_IR,
	input wire logic [15:0] SAMPLE_RED,
	input wire logic [1:0] ADC_RES,
	input wire logic TEMP_DONE,
	// Status
	output logic FIFO_EMPTY,
	output logic FIFO_FULL
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic sda_m;
		logic sda_s;
		logic sda_p;
		logic sup_m;
		logic sup_s;
		logic sup_p;
		ssf_pkg::ssf_bus_state_type bus;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic rw;
		logic acked;
		logic sda_oe;
		logic [7:0] reg_addr;
		logic [4:0] flags;
		logic [3:0] masks;
		logic [3:0] wr;
		logic [3:0] rd;
		logic [3:0] lost;
		logic full;
		logic [1:0] byte_sel;
		logic int_on;
	} ssf_top_state_type;

	ssf_top_state_type s_q;
	ssf_top_state_type s_d;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sup_rise;
	logic mode_pulse;
	logic mode_oxy;
	logic mode_active;
	logic [1:0] just_sh;
	logic [15:0] ir_just;
	logic [15:0] red_just;
	logic [31:0] ram_q;
	logic ram_we;
	logic [3:0] ram_wa;
	logic [7:0] flag_byte;
	logic [7:0] fifo_byte;
	logic [7:0] reg_rdata;
	logic int_want;

	// ****************************************
	// Edge and condition detect
	// ****************************************
	assign scl_rise = s_q.scl_s & ~s_q.scl_p;
	assign scl_fall = ~s_q.scl_s & s_q.scl_p;
	// Start and stop only count while the clock stays high
	assign bus_start = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
	assign bus_stop = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
	assign sup_rise = s_q.sup_s & ~s_q.sup_p;

	assign mode_pulse = (MODE_SEL == ssf_pkg::MODE_PULSE);
	assign mode_oxy = (MODE_SEL == ssf_pkg::MODE_OXY);
	assign mode_active = mode_pulse | mode_oxy;

	// ****************************************
	// Sample storage
	// ****************************************
	// Narrow results arrive right-justified; shift up to bit fifteen
	assign just_sh = ssf_pkg::RES_FULL - ADC_RES;
	assign ir_just = SAMPLE_IR << just_sh;
	assign red_just = SAMPLE_RED << just_sh;

	ssf_sample_ram #(
		.DEPTH(ssf_pkg::FIFO_DEPTH),
		.AW(ssf_pkg::IDX_W),
		.DW(ssf_pkg::SAMPLE_W)
	) u_ram (
		.clk(CLK_SYS),
		.we(ram_we),
		.wa(ram_wa),
		.wd({ir_just, red_just}),
		.ra(s_q.rd),
		.rd(ram_q)
	);

	// ****************************************
	// Read data
	// ****************************************
	assign flag_byte = {s_q.flags[ssf_pkg::FLG_ALMOST:ssf_pkg::FLG_OXY], 3'h0,
		s_q.flags[ssf_pkg::FLG_SUPPLY]};

	// Red half blanked at read time only while in pulse mode, so a later switch to oxygen exposes it
	assign fifo_byte = (s_q.byte_sel == 2'h0) ? ram_q[31:24] :
		(s_q.byte_sel == 2'h1) ? ram_q[23:16] :
		mode_pulse ? 8'h00 :
		(s_q.byte_sel == 2'h2) ? ram_q[15:8] :
		ram_q[7:0];

	assign reg_rdata = (s_q.reg_addr == ssf_pkg::REG_INT_FLAGS) ? flag_byte :
		(s_q.reg_addr == ssf_pkg::REG_INT_MASK) ? {s_q.masks, 4'h0} :
		(s_q.reg_addr == ssf_pkg::REG_WR_IDX) ? {4'h0, s_q.wr} :
		(s_q.reg_addr == ssf_pkg::REG_LOST) ? {4'h0, s_q.lost} :
		(s_q.reg_addr == ssf_pkg::REG_RD_IDX) ? {4'h0, s_q.rd} :
		(s_q.reg_addr == ssf_pkg::REG_FIFO_PORT) ? fifo_byte :
		ssf_pkg::READ_NONE;

	// Supply flag has no mask bit
	assign int_want = (|(s_q.flags[ssf_pkg::FLG_ALMOST:ssf_pkg::FLG_OXY] & s_q.masks))
		| s_q.flags[ssf_pkg::FLG_SUPPLY];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic load;
		logic wr_hit;
		logic step_addr;
		logic [3:0] wr_next;
		load = 1'b0;
		wr_hit = 1'b0;
		step_addr = 1'b0;
		wr_next = 4'h0;
		s_d = s_q;
		ram_we = 1'b0;
		ram_wa = s_q.wr;

		// Two flops per pin before anything looks at it
		s_d.scl_m = SCL_IN;
		s_d.scl_s = s_q.scl_m;
		s_d.scl_p = s_q.scl_s;
		s_d.sda_m = SDA_IN;
		s_d.sda_s = s_q.sda_m;
		s_d.sda_p = s_q.sda_s;
		s_d.sup_m = SUPPLY_OK;
		s_d.sup_s = s_q.sup_m;
		s_d.sup_p = s_q.sup_s;

		// Bus engine
		if (bus_start) begin
			s_d.bus = ssf_pkg::ST_ADDR;
			s_d.bit_cnt = 4'h0;
			s_d.sda_oe = 1'b0;
		end else if (bus_stop) begin
			s_d.bus = ssf_pkg::ST_IDLE;
			s_d.sda_oe = 1'b0;
		end else begin
			case (s_q.bus)
				ssf_pkg::ST_IDLE: begin
					s_d.sda_oe = 1'b0;
				end
				ssf_pkg::ST_ADDR, ssf_pkg::ST_REG, ssf_pkg::ST_WDATA: begin
					if (scl_rise) begin
						s_d.shift = {s_q.shift[6:0], s_q.sda_s};
						s_d.bit_cnt = s_q.bit_cnt + 4'h1;
					end else if (scl_fall && s_q.bit_cnt == ssf_pkg::BYTE_BITS) begin
						s_d.bit_cnt = 4'h0;
						if (s_q.bus == ssf_pkg::ST_ADDR) begin
							if (s_q.shift[7:1] == DEV_ADDR) begin
								s_d.rw = s_q.shift[0];
								s_d.sda_oe = 1'b1;
								s_d.bus = ssf_pkg::ST_ADDR_ACK;
							end else begin
								s_d.bus = ssf_pkg::ST_IDLE;
							end
						end else if (s_q.bus == ssf_pkg::ST_REG) begin
							s_d.reg_addr = s_q.shift;
							s_d.sda_oe = 1'b1;
							s_d.bus = ssf_pkg::ST_REG_ACK;
						end else begin
							wr_hit = 1'b1;
							s_d.sda_oe = 1'b1;
							s_d.bus = ssf_pkg::ST_WACK;
						end
					end
				end
				ssf_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (s_q.rw) begin
							load = 1'b1;
						end else begin
							s_d.sda_oe = 1'b0;
							s_d.bus = ssf_pkg::ST_REG;
						end
					end
				end
				ssf_pkg::ST_REG_ACK, ssf_pkg::ST_WACK: begin
					if (scl_fall) begin
						s_d.sda_oe = 1'b0;
						s_d.bus = ssf_pkg::ST_WDATA;
					end
				end
				ssf_pkg::ST_RDATA: begin
					if (scl_rise) begin
						s_d.bit_cnt = s_q.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_q.bit_cnt == ssf_pkg::BYTE_BITS) begin
							s_d.sda_oe = 1'b0;
							s_d.bit_cnt = 4'h0;
							s_d.bus = ssf_pkg::ST_RACK;
						end else begin
							s_d.shift = {s_q.shift[6:0], 1'b0};
							s_d.sda_oe = ~s_q.shift[6];
						end
					end
				end
				ssf_pkg::ST_RACK: begin
					if (scl_rise) begin
						s_d.acked = ~s_q.sda_s;
					end else if (scl_fall) begin
						if (s_q.acked) begin
							load = 1'b1;
						end else begin
							s_d.bus = ssf_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					s_d.bus = ssf_pkg::ST_IDLE;
					s_d.sda_oe = 1'b0;
				end
			endcase
		end

		// Byte fetch for the controller, with read side effects
		if (load) begin
			s_d.shift = reg_rdata;
			s_d.sda_oe = ~reg_rdata[7];
			s_d.bit_cnt = 4'h0;
			s_d.bus = ssf_pkg::ST_RDATA;
			step_addr = 1'b1;
			if (s_q.reg_addr == ssf_pkg::REG_INT_FLAGS || s_q.reg_addr == ssf_pkg::REG_FIFO_PORT) begin
				s_d.flags = ssf_pkg::RST_FLAGS;
			end
			if (s_q.reg_addr == ssf_pkg::REG_FIFO_PORT) begin
				s_d.byte_sel = s_q.byte_sel + 2'h1;
				if (s_q.byte_sel == ssf_pkg::LAST_BYTE) begin
					s_d.rd = s_q.rd + 4'h1;
					s_d.lost = ssf_pkg::RST_LOST;
					s_d.full = 1'b0;
				end
			end
		end

		// Register writes; low mask bits are dropped
		if (wr_hit) begin
			step_addr = 1'b1;
			case (s_q.reg_addr)
				ssf_pkg::REG_INT_MASK: begin
					s_d.masks = s_q.shift[7:ssf_pkg::MASK_LSB];
				end
				ssf_pkg::REG_WR_IDX: begin
					if (MODE_SEL != ssf_pkg::MODE_OFF) begin
						s_d.wr = s_q.shift[3:0];
						s_d.full = 1'b0;
					end
				end
				ssf_pkg::REG_LOST: begin
					s_d.lost = s_q.shift[3:0];
				end
				ssf_pkg::REG_RD_IDX: begin
					s_d.rd = s_q.shift[3:0];
					s_d.byte_sel = 2'h0;
					s_d.full = 1'b0;
				end
				default: begin
					s_d.lost = s_d.lost;
				end
			endcase
		end

		// Data port keeps its address; the top address never wraps
		if (step_addr && s_q.reg_addr != ssf_pkg::REG_FIFO_PORT
			&& s_q.reg_addr != ssf_pkg::REG_LAST) begin
			s_d.reg_addr = s_q.reg_addr + 8'h01;
		end

		// Sample push; sets come after clears so a same-cycle event survives
		if (SAMPLE_STROBE && mode_active) begin
			s_d.flags[ssf_pkg::FLG_PULSE] = 1'b1;
			if (mode_oxy) begin
				s_d.flags[ssf_pkg::FLG_OXY] = 1'b1;
			end
			if (s_d.full) begin
				if (s_d.lost != ssf_pkg::LOST_MAX) begin
					s_d.lost = s_d.lost + 4'h1;
				end
			end else begin
				ram_we = 1'b1;
				ram_wa = s_d.wr;
				wr_next = s_d.wr + 4'h1;
				s_d.wr = wr_next;
				if (wr_next == s_d.rd) begin
					s_d.full = 1'b1;
				end
				if (wr_next == s_d.rd - 4'h1) begin
					s_d.flags[ssf_pkg::FLG_ALMOST] = 1'b1;
				end
			end
		end
		if (TEMP_DONE) begin
			s_d.flags[ssf_pkg::FLG_TEMP] = 1'b1;
		end

		// Below lockout the FIFO indexes, lost count, flags and masks return to power-on values
		if (!s_q.sup_s) begin
			s_d.wr = ssf_pkg::RST_IDX;
			s_d.rd = ssf_pkg::RST_IDX;
			s_d.lost = ssf_pkg::RST_LOST;
			s_d.full = 1'b0;
			s_d.byte_sel = 2'h0;
			s_d.masks = ssf_pkg::RST_MASK;
			s_d.flags = ssf_pkg::RST_FLAGS;
			ram_we = 1'b0;
		end
		if (sup_rise) begin
			s_d.flags[ssf_pkg::FLG_SUPPLY] = 1'b1;
		end

		// Power save silences flags but leaves the bus working
		if (POWER_SAVE) begin
			s_d.flags = ssf_pkg::RST_FLAGS;
		end

		s_d.int_on = int_want;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign SDA_OUT = 1'b0;
	assign SDA_OE = s_q.sda_oe;
	assign INT_N_OUT = 1'b0;
	assign INT_N_OE = s_q.int_on;
	assign FIFO_EMPTY = (s_q.wr == s_q.rd) & ~s_q.full;
	assign FIFO_FULL = s_q.full;

endmodule

// ### verif/ssf_sva.sv
`timescale 1ns/1ps

module ssf_chk (
	// System
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Pins
	input wire logic SCL_IN,
	input wire logic INT_N_OUT,
	input wire logic INT_N_OE,
	input wire logic SUPPLY_OK,
	input wire logic [2:0] MODE_SEL,
	input wire logic POWER_SAVE,
	input wire logic SAMPLE_STROBE,
	input wire logic FIFO_EMPTY,
	input wire logic FIFO_FULL
);
	// ****
	// Checks
	// ****
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	a_pin_pulls_low: assert property (INT_N_OUT == 1'b0)
		else $error("interrupt pin drives high");
	a_save_quiets_pin: assert property (POWER_SAVE [*3] |-> !INT_N_OE)
		else $error("interrupt active in power save");
	a_supply_rise_int: assert property ($rose(SUPPLY_OK) ##0 (SUPPLY_OK && !POWER_SAVE) [*6] |-> INT_N_OE)
		else $error("supply recovery gave no interrupt");
	a_brownout_clears: assert property (!SUPPLY_OK [*5] |-> FIFO_EMPTY && !INT_N_OE)
		else $error("brownout left state behind");
	a_full_not_empty: assert property (!(FIFO_FULL && FIFO_EMPTY))
		else $error("full and empty together");
	a_full_from_push: assert property ($rose(FIFO_FULL) |-> $past(SAMPLE_STROBE))
		else $error("full without a push");
	// Bus side effects land while the clock pin is low, so a high pin rules them out
	a_idle_no_push: assert property (SAMPLE_STROBE && MODE_SEL == 3'h0 && FIFO_EMPTY && SCL_IN |=> FIFO_EMPTY)
		else $error("sample stored in idle mode");
	a_push_fills: assert property (SAMPLE_STROBE && MODE_SEL[2:1] == 2'h1 && SCL_IN |=> !FIFO_EMPTY)
		else $error("push left buffer empty");

	c_full: cover property (FIFO_FULL && SAMPLE_STROBE);
	c_save: cover property (POWER_SAVE && SAMPLE_STROBE);
	c_brown: cover property ($fell(SUPPLY_OK));
endmodule

bind ssf_top ssf_chk i_ssf_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SCL_IN(SCL_IN), .INT_N_OUT(INT_N_OUT),
	.INT_N_OE(INT_N_OE), .SUPPLY_OK(SUPPLY_OK), .MODE_SEL(MODE_SEL), .POWER_SAVE(POWER_SAVE),
	.SAMPLE_STROBE(SAMPLE_STROBE), .FIFO_EMPTY(FIFO_EMPTY), .FIFO_FULL(FIFO_FULL));

// ### verif/ssf_host.sv
`timescale 1ns/1ps

module ssf_host #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// Bus pins
	output logic scl,
	input wire logic sda,
	output logic drv
);
	// Clock stands high between frames
	initial begin
		scl = 1'b1;
		drv = 1'b0;
	end

	// ****
	// Bit and byte level
	// ****
	task automatic bit_io(input logic o, output logic i);
		drv = ~o;
		#50 scl = 1'b1;
		#90 i = sda;
		#10 scl = 1'b0;
		#50;
	endtask

	// Released data bits let the device answer
	task automatic xfer(input logic [7:0] o, input logic ack, output logic [7:0] i);
		logic a;
		for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
		bit_io(ack, a);
	endtask

	task automatic start;
		drv = 1'b0;
		#50 scl = 1'b1;
		#50 drv = 1'b1;
		#100 scl = 1'b0;
		#50;
	endtask

	task automatic stop;
		drv = 1'b1;
		#50 scl = 1'b1;
		#50 drv = 1'b0;
		#100;
	endtask

	// ****
	// Register access
	// ****
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic [7:0] x;
		start();
		xfer({ADDR, 1'b0}, 1'b1, x);
		xfer(r, 1'b1, x);
		xfer(d, 1'b1, x);
		stop();
	endtask

	task automatic rd(input logic [7:0] r, input int n, output logic [7:0] q [8]);
		logic [7:0] x;
		start();
		xfer({ADDR, 1'b0}, 1'b1, x);
		xfer(r, 1'b1, x);
		start();
		xfer({ADDR, 1'b1}, 1'b1, x);
		for (int k = 0; k < n; k++) xfer(8'hFF, k == n - 1, q[k]);
		stop();
	endtask
endmodule

// ### verif/ssf_top_tb.sv
`timescale 1ns/1ps

module ssf_top_tb;
	logic clk = 0, rst_n = 0, sup = 1, save = 0, stb = 0, tmp = 0;
	logic scl, sda, sda_oe, sda_out, int_oe, int_out, emp, ful, hdrv;
	logic [2:0] mode = 3'h0;
	logic [1:0] res = 2'h3;
	logic [15:0] ir = 16'h0000, red = 16'h0000;
	logic [7:0] b [8];
	logic [15:0] exp_q [$];
	int n_mismatch = 0, checks_done = 0, stored = 0, seed = 32'h9BF538D8;

	// Wired bus: the device's pin value counts only while it drives, so a wrong drive level breaks the ack
	assign sda = ~hdrv & (~sda_oe | sda_out);
	initial forever #12.5 clk = ~clk;

	ssf_top i_ssf_top (.CLK_SYS(clk), .RESET_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .INT_N_OUT(int_out), .INT_N_OE(int_oe), .SUPPLY_OK(sup), .MODE_SEL(mode),
		.POWER_SAVE(save), .SAMPLE_STROBE(stb), .SAMPLE_IR(ir), .SAMPLE_RED(red), .ADC_RES(res),
		.TEMP_DONE(tmp), .FIFO_EMPTY(emp), .FIFO_FULL(ful));
	ssf_host i_ssf_host (.scl(scl), .sda(sda), .drv(hdrv));

	// ****
	// Helpers
	// ****
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [15:0] lj(input logic [15:0] x);
		return x << (2'h3 - res);
	endfunction

	function automatic logic [7:0] exp_byte(input int s, input int i);
		logic [15:0] w;
		w = exp_q[2 * s + i / 2];
		return i[0] ? w[7:0] : w[15:8];
	endfunction

	// Only the first sixteen stored samples can be read back
	task automatic push;
		res = $random(seed);
		ir = $random(seed) & (16'hFFFF >> (2'h3 - res));
		red = $random(seed) & (16'hFFFF >> (2'h3 - res));
		stb = 1'b1;
		if (mode[2:1] == 2'b01) begin
			if (stored < 16) begin
				exp_q.push_back(lj(ir));
				exp_q.push_back(mode[0] ? lj(red) : 16'h0000);
			end
			stored++;
		end
		tick(1);
		stb = 1'b0;
		tick(1);
	endtask

	task automatic wreg(input logic [7:0] r, input logic [7:0] d);
		i_ssf_host.wr(r, d);
		tick(2);
	endtask

	task automatic rregs(input logic [7:0] r, input logic [39:0] e, input int n);
		i_ssf_host.rd(r, n, b);
		tick(2);
		for (int i = 0; i < n; i++) chk(b[i], e[8 * (n - 1 - i) +: 8]);
	endtask

	task automatic rdat(input int s, input int n);
		i_ssf_host.rd(8'h05, n, b);
		tick(2);
		for (int i = 0; i < n; i++) chk(b[i], exp_byte(s + i / 4, i % 4));
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		tick(80000);
		n_mismatch++;
		summarize();
	end

	// ****
	// Scenarios
	// ****
	initial begin
		tick(4);
		rst_n = 1'b1;
		tick(6);
		chk({7'h00, int_oe}, 8'h01);
		rregs(8'h00, 40'h0100000000, 5);
		chk({7'h00, int_oe}, 8'h00);
		mode = 3'h3;
		wreg(8'h01, 8'hF0);
		repeat (17) push();
		chk({7'h00, ful}, 8'h01);
		chk({7'h00, int_oe}, 8'h01);
		rregs(8'h00, 40'hB0F0000100, 5);
		rdat(0, 8);
		rregs(8'h00, 40'h00F0000002, 5);
		wreg(8'h04, 8'h01);
		rdat(1, 4);
		tmp = 1'b1;
		tick(1);
		tmp = 1'b0;
		tick(2);
		chk({7'h00, int_oe}, 8'h01);
		wreg(8'h01, 8'h00);
		chk({7'h00, int_oe}, 8'h00);
		rregs(8'h00, 40'h40, 1);
		mode = 3'h2;
		wreg(8'h02, 8'h00);
		wreg(8'h04, 8'h00);
		wreg(8'h03, 8'h00);
		exp_q.delete();
		stored = 0;
		mode = 3'h0;
		push();
		chk({7'h00, emp}, 8'h01);
		mode = 3'h2;
		push();
		rregs(8'h00, 40'h20, 1);
		rdat(0, 4);
		mode = 3'h0;
		wreg(8'h02, 8'h05);
		rregs(8'h02, 40'h01, 1);
		mode = 3'h3;
		wreg(8'h02, 8'h05);
		rregs(8'h02, 40'h05, 1);
		// Sources enabled first, so a quiet pin in power save means something
		wreg(8'h01, 8'hF0);
		save = 1'b1;
		push();
		tmp = 1'b1;
		tick(1);
		tmp = 1'b0;
		tick(2);
		chk({7'h00, int_oe}, 8'h00);
		rregs(8'h00, 40'h00, 1);
		save = 1'b0;
		rregs(8'h20, 40'h00, 1);
		rregs(8'hFF, 40'h000000, 3);
		wreg(8'h01, 8'hF0);
		sup = 1'b0;
		tick(8);
		sup = 1'b1;
		tick(8);
		chk({7'h00, int_oe}, 8'h01);
		rregs(8'h00, 40'h0100000000, 5);
		summarize();
	end
endmodule
